// [auth_cmd_pkg.sv]
// types shared by the authentication command tail
// assumes the constants header is available on the include path
package auth_cmd_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_OPC  = 2'b01,
    ST_BODY = 2'b11,
    ST_DEAD = 2'b10
  } frame_t;

  typedef struct packed {
    logic [95:0]  tag;
    logic [31:0]  counter;
    logic [255:0] signature;
  } payload_t;

  typedef struct packed {
    logic [2:0] sck;
    logic [1:0] cs_n;
    logic [1:0] mosi;
  } sync_t;
endpackage : auth_cmd_pkg

// [auth_cmd_regs.svh]
// constants for the authentication command tail: opcodes, frame sizes, timing
// assumes inclusion by the top module only
`ifndef AUTH_CMD_REGS_SVH
`define AUTH_CMD_REGS_SVH
`define OPC_SECURE       8'h9B
`define OPC_READOUT      8'h96
`define OPC_RST_ARM      8'h66
`define OPC_RST_GO       8'h99
`define TYPE_LAST_VALID  8'h03
`define TYPE_COUNTER_REQ 8'h03
`define STAT_RESERVED_BIT 2
`define STAT_BUSY_BIT    0
`define STAT_RESET       8'h00
`define PAYLOAD_BYTES    49
`define RST_TIME_NS      30000
`define CLK_PERIOD_NS    4
`define RST_CYCLES       ((`RST_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// [auth_status_reset_cmd.sv]
// command tail of the authentication unit: reserved types, readout, soft reset
// assumes engine results arrive on clk; spi pins are raw and asynchronous
`timescale 1ns/100ps
`include "auth_cmd_regs.svh"
module auth_status_reset_cmd
  import auth_cmd_pkg::*;
#(
  parameter int RST_CYCLES = `RST_CYCLES
)(
  input  wire logic     clk,          // 250 MHz system clock
  input  wire logic     reset,        // async, active high (power-up)
  input  wire logic     sck,          // serial clock from host
  input  wire logic     cs_n,         // chip select, active low
  input  wire logic     mosi,         // serial data in
  input  wire logic     eng_busy,     // engine busy level
  input  wire logic     eng_done,     // pulse: engine finished frame
  input  wire logic [7:0] eng_status, // engine completion status
  input  wire payload_t eng_payload,  // counter request result
  output logic          miso,         // serial data out
  output logic          miso_oe,      // high while driving miso
  output logic          cmd_start,    // pulse: valid secure type accepted
  output logic [7:0]    cmd_type,     // accepted command type
  output logic          auth_abort,   // pulse: soft reset, auth logic only
  output logic [7:0]    status,       // current status byte
  output logic          recovering    // high during post-reset recovery
);
  typedef struct packed {
    frame_t     st;
    logic [7:0] opc;
    logic [5:0] idx;
    logic       armed;
    logic       is_req;
    logic       payload_ok;
    logic [7:0] stat;
    logic [7:0] ctype;
    logic       start;
    logic       abort;
    logic [31:0] rcnt;
    logic       rec;
    logic       oe;
    payload_t   pl;
  } state_t;
  state_t q, d;

  // what the host sees in each readout byte slot
  typedef enum logic [2:0] {
    SLOT_NONE    = 3'b000,
    SLOT_DUMMY   = 3'b001,
    SLOT_STATUS  = 3'b011,
    SLOT_PAYLOAD = 3'b010,
    SLOT_FILL    = 3'b110
  } slot_t;
  slot_t slot_now;

  logic       sel, rx_valid, tx_load, sh_miso;
  logic [7:0] rx_byte, tx_byte;

  function automatic logic [7:0] pay_byte(input payload_t p, input logic [5:0] i);
    logic [383:0] flat;
    flat     = p;
    pay_byte = flat[383 - 8*(i - 6'd3) -: 8];
  endfunction : pay_byte

  // shared by the output mux and the drive enable
  function automatic slot_t slot_of(input frame_t st, input logic [7:0] opc,
                                    input logic [5:0] idx, input logic busy);
    slot_t s;
    s = SLOT_NONE;
    if (st == ST_BODY && opc == `OPC_READOUT) begin
      if (idx < 6'd2)                                   s = SLOT_DUMMY;
      else if (idx == 6'd2 || busy)                     s = SLOT_STATUS;
      else if (idx < 6'd3 + 6'(`PAYLOAD_BYTES) - 6'd1) s = SLOT_PAYLOAD;
      else                                              s = SLOT_FILL;
    end
    slot_of = s;
  endfunction : slot_of

  spi_byte_shifter u_shf (
    .clk      (clk),
    .reset    (reset),
    .sck      (sck),
    .cs_n     (cs_n),
    .mosi     (mosi),
    .tx_byte  (tx_byte),
    .miso     (sh_miso),
    .sel      (sel),
    .rx_valid (rx_valid),
    .rx_byte  (rx_byte),
    .tx_load  (tx_load)
  );

  // byte for the next slot; idx counts bytes already started
  always_comb begin
    tx_byte  = 8'h00;
    slot_now = slot_of(q.st, q.opc, q.idx, q.stat[`STAT_BUSY_BIT]);
    unique case (slot_now)
      SLOT_STATUS:  tx_byte = q.stat;
      SLOT_PAYLOAD: tx_byte = q.payload_ok ? pay_byte(q.pl, q.idx) : 8'h00;
      default:      tx_byte = 8'h00;
    endcase
  end

  always_comb begin
    d       = q;
    d.start = 1'b0;
    d.abort = 1'b0;
    d.oe    = sel && slot_now != SLOT_NONE && slot_now != SLOT_DUMMY;
    if (q.rcnt != 32'd0) d.rcnt = q.rcnt - 32'd1;
    if (eng_done) begin
      d.stat       = eng_status;
      d.payload_ok = q.is_req && (eng_status == `STAT_RESET);
      d.pl         = eng_payload;
    end
    d.stat[`STAT_BUSY_BIT] = eng_busy;
    if (tx_load && q.st == ST_BODY) d.idx = q.idx + 6'd1;
    if (!sel) begin
      d.st  = ST_IDLE;
      d.idx = 6'd1;
    end else unique case (q.st)
      ST_IDLE: d.st = (q.rcnt != 32'd0) ? ST_DEAD : ST_OPC;
      ST_OPC: if (rx_valid) begin
        d.opc   = rx_byte;
        d.st    = ST_BODY;
        d.idx   = 6'd1;
        d.armed = (rx_byte == `OPC_RST_ARM);
        if (rx_byte == `OPC_RST_GO && q.armed) begin
          d.abort      = 1'b1;
          d.stat       = `STAT_RESET;
          d.payload_ok = 1'b0;
          d.is_req     = 1'b0;
          d.pl         = '0;
          d.ctype      = 8'h00;
          d.rcnt       = 32'(RST_CYCLES);
          d.st         = ST_DEAD;
        end
      end
      // type byte ends after its own load has moved idx to 2
      ST_BODY: if (rx_valid && q.opc == `OPC_SECURE && q.idx == 6'd2) begin
        d.idx = 6'd3;
        if (rx_byte > `TYPE_LAST_VALID) begin
          d.stat = 8'h01 << `STAT_RESERVED_BIT;
          d.payload_ok = 1'b0;
          d.is_req     = 1'b0;
        end else begin
          d.start      = 1'b1;
          d.ctype      = rx_byte;
          d.is_req     = (rx_byte == `TYPE_COUNTER_REQ);
          d.payload_ok = 1'b0;
        end
      end
      ST_DEAD: d.st = ST_DEAD;
    endcase
    d.rec = (d.rcnt != 32'd0);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      q      <= '0;
      q.st   <= ST_IDLE;
      q.idx  <= 6'd1;
    end else begin
      q <= d;
    end
  end

  assign miso       = sh_miso;
  assign miso_oe    = q.oe;
  assign cmd_start  = q.start;
  assign cmd_type   = q.ctype;
  assign auth_abort = q.abort;
  assign status     = q.stat;
  assign recovering = q.rec;
endmodule : auth_status_reset_cmd

// [auth_status_reset_cmd_bench.sv]
// bench: reserved, valid, busy and reset frames with random payloads
// assumes the host model and the bound checker
`timescale 1ns/100ps
module auth_status_reset_cmd_bench;
  import auth_cmd_pkg::*;
  logic       clk, reset, eng_busy, eng_done, sck, cs_n, mosi, miso, miso_oe;
  logic       cmd_start, auth_abort, recovering;
  logic [7:0] eng_status, cmd_type, status, st, t, err;
  payload_t   eng_payload, pl;
  int         fail_count, num_checks, seed, starts, aborts;
  always #2 clk = ~clk;
  always @(posedge clk) begin
    if (cmd_start === 1'b1) starts <= starts + 1;
    if (auth_abort === 1'b1) aborts <= aborts + 1;
  end
  spi_host_model host_u (.sck(sck), .cs_n(cs_n), .mosi(mosi), .miso(miso));
  auth_status_reset_cmd #(.RST_CYCLES(500)) dut_u (.clk(clk), .reset(reset), .sck(sck),
    .cs_n(cs_n), .mosi(mosi), .eng_busy(eng_busy), .eng_done(eng_done),
    .eng_status(eng_status), .eng_payload(eng_payload), .miso(miso), .miso_oe(miso_oe),
    .cmd_start(cmd_start), .cmd_type(cmd_type), .auth_abort(auth_abort), .status(status),
    .recovering(recovering));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // busy readout repeats the status; otherwise status then payload
  task automatic readout(input logic [7:0] s, input payload_t p, input bit bz, input int n);
    logic [391:0] v;
    v = {s, p};
    host_u.frame(8'h96, 8'h00, n);
    for (int i = 2; i < n; i++) chk(host_u.rx_bytes[i], bz ? s : v[391-8*(i-2) -: 8]);
  endtask : readout
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict
  initial begin
    {clk, eng_busy, eng_done, eng_status, eng_payload} = '0;
    {fail_count, num_checks, starts, aborts} = '0;
    reset = 1'b1;
    seed = 29692;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    repeat (4) @(posedge clk);
    // power-up write wait shortened to keep the run short; model never writes keys
    for (int i = 0; i < 6; i++) begin
      t = (i == 0) ? 8'h04 : (i == 1) ? 8'hFF : 8'h04 + 8'($unsigned($random(seed)) % 252);
      host_u.frame(8'h9B, t, 2);
      chk(status, 8'h04);
      readout(8'h04, '0, 0, 3 + i);
    end
    chk(8'(starts), 8'h00);
    for (int k = 0; k < 5; k++) begin
      t = (k == 4) ? 8'h03 : 8'(k);
      err = (k == 4) ? 8'h08 : 8'h00;
      st = status;
      host_u.frame(8'h9B, t, 2);
      chk(cmd_type, t);
      chk(8'(starts), 8'(k + 1));
      @(posedge clk);
      eng_busy <= 1'b1;
      repeat (3) @(posedge clk);
      readout(st | 8'h01, '0, 1, 6);
      for (int w = 0; w < 12; w++) pl[w*32 +: 32] = $random(seed);
      @(posedge clk);
      {eng_busy, eng_done, eng_status, eng_payload} <= {2'b01, err, pl};
      @(posedge clk);
      eng_done <= 1'b0;
      repeat (3) @(posedge clk);
      readout(err, (t == 8'h03 && err == 8'h00) ? pl : '0, 0, 51);
    end
    chk(status, 8'h08);
    host_u.frame(8'h66, 8'h00, 1);
    host_u.frame(8'h00, 8'h00, 1);
    host_u.frame(8'h99, 8'h00, 1);
    chk(8'(aborts), 8'h00);
    host_u.frame(8'h66, 8'h00, 1);
    host_u.frame(8'h99, 8'h00, 1);
    chk(8'(aborts), 8'h01);
    chk(status, 8'h00);
    chk(cmd_type, 8'h00);
    host_u.frame(8'h9B, 8'h01, 2);
    chk(8'(starts), 8'h05);
    for (int w = 0; w < 1000 && recovering !== 1'b0; w++) @(posedge clk);
    chk({7'h00, recovering}, 8'h00);
    if (recovering === 1'b0) begin
      host_u.frame(8'h9B, 8'h02, 2);
      chk(8'(starts), 8'h06);
    end
    give_verdict();
  end
endmodule : auth_status_reset_cmd_bench

// [auth_status_reset_cmd_chk.sv]
// checker: port-level properties of the command tail
// assumes binding onto the top module, one clock domain
`timescale 1ns/100ps
module auth_status_reset_cmd_chk (
  input wire logic       clk,        // clock
  input wire logic       reset,      // async reset
  input wire logic       cs_n,       // chip select
  input wire logic       eng_busy,   // engine busy
  input wire logic       eng_done,   // engine done
  input wire logic [7:0] eng_status, // engine status
  input wire logic       miso_oe,    // drive enable
  input wire logic       cmd_start,  // start pulse
  input wire logic [7:0] cmd_type,   // started type
  input wire logic       auth_abort, // abort pulse
  input wire logic [7:0] status,     // status byte
  input wire logic       recovering  // recovery level
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_abort; auth_abort ##1 recovering; endsequence
  sequence s_idle; cs_n [*6]; endsequence
  property p_type; cmd_start |-> cmd_type <= 8'h03; endproperty
  a_type: assert property (p_type) else $error("reserved type started");
  property p_recov; recovering |-> !cmd_start; endproperty
  a_recov: assert property (p_recov) else $error("start during recovery");
  property p_abort; auth_abort |-> s_abort; endproperty
  a_abort: assert property (p_abort) else $error("no recovery after abort");
  property p_pulse; s_abort |-> !auth_abort; endproperty
  a_pulse: assert property (p_pulse) else $error("abort not a pulse");
  property p_clear; auth_abort |=> status[7:1] == 7'h00; endproperty
  a_clear: assert property (p_clear) else $error("status kept over reset");
  property p_busy; !auth_abort |-> status[0] == $past(eng_busy); endproperty
  a_busy: assert property (p_busy) else $error("busy bit stale");
  property p_done;
    eng_done && !recovering ##1 !auth_abort |-> status[7:1] == $past(eng_status[7:1]);
  endproperty
  a_done: assert property (p_done) else $error("status not from last frame");
  property p_idle; s_idle |-> !miso_oe; endproperty
  a_idle: assert property (p_idle) else $error("driving while deselected");
endmodule : auth_status_reset_cmd_chk
bind auth_status_reset_cmd auth_status_reset_cmd_chk chk_u (.clk(clk), .reset(reset),
  .cs_n(cs_n), .eng_busy(eng_busy), .eng_done(eng_done), .eng_status(eng_status),
  .miso_oe(miso_oe), .cmd_start(cmd_start), .cmd_type(cmd_type), .auth_abort(auth_abort),
  .status(status), .recovering(recovering));

// [spi_byte_shifter.sv]
// spi mode 0 byte shifter running on the system clock
// assumes sck and cs_n arrive raw; both are synchronised here
`timescale 1ns/100ps
module spi_byte_shifter
  import auth_cmd_pkg::*;
(
  input  wire logic       clk,        // system clock
  input  wire logic       reset,      // async, active high
  input  wire logic       sck,        // serial clock pin
  input  wire logic       cs_n,       // chip select pin, active low
  input  wire logic       mosi,       // serial data in
  input  wire logic [7:0] tx_byte,    // byte to shift out next
  output logic            miso,       // serial data out
  output logic            sel,        // frame active, synchronised
  output logic            rx_valid,   // one-cycle pulse, byte taken
  output logic [7:0]      rx_byte,    // received byte
  output logic            tx_load     // one-cycle pulse, tx_byte latched
);
  typedef struct packed {
    sync_t      s;
    logic [2:0] bits;
    logic [7:0] sh_in;
    logic [7:0] sh_out;
    logic       miso;
    logic       rx_valid;
    logic [7:0] rx_byte;
    logic       tx_load;
  } shf_t;
  shf_t q, d;
  logic rise, fall, act;

  always_comb begin
    d        = q;
    d.s.sck  = {q.s.sck[1:0], sck};
    d.s.cs_n = {q.s.cs_n[0], cs_n};
    d.s.mosi = {q.s.mosi[0], mosi};
    rise     = q.s.sck[1] & ~q.s.sck[2];
    fall     = ~q.s.sck[1] & q.s.sck[2];
    act      = ~q.s.cs_n[1];
    d.rx_valid = 1'b0;
    d.tx_load  = 1'b0;
    if (!act) begin
      d.bits   = 3'd0;
      d.sh_out = tx_byte;
      d.miso   = tx_byte[7];
    end else begin
      if (rise) begin
        d.sh_in = {q.sh_in[6:0], q.s.mosi[1]};
        d.bits  = q.bits + 3'd1;
        if (q.bits == 3'd7) begin
          d.rx_valid = 1'b1;
          d.rx_byte  = {q.sh_in[6:0], q.s.mosi[1]};
        end
      end
      if (fall) begin
        if (q.bits == 3'd0) begin
          d.sh_out  = tx_byte;
          d.miso    = tx_byte[7];
          d.tx_load = 1'b1;
        end else begin
          d.miso   = q.sh_out[6];
          d.sh_out = {q.sh_out[6:0], 1'b0};
        end
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      q        <= '0;
      q.s.cs_n <= 2'b11; // start deselected, so no false frame follows reset
    end else begin
      q <= d;
    end
  end

  assign miso     = q.miso;
  assign sel      = ~q.s.cs_n[1];
  assign rx_valid = q.rx_valid;
  assign rx_byte  = q.rx_byte;
  assign tx_load  = q.tx_load;
endmodule : spi_byte_shifter

// [spi_host_model.sv]
// host model: mode 0 frames, msb first, bytes kept in rx_bytes
// assumes callers run frame() one at a time
`timescale 1ns/100ps
module spi_host_model (
  output logic      sck,  // serial clock, still between frames
  output logic      cs_n, // chip select
  output logic      mosi, // data to device
  input  wire logic miso  // data from device
);
  logic [7:0] rx_bytes [0:63];
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  task automatic frame(input logic [7:0] op, input logic [7:0] arg, input int n);
    logic [7:0] b;
    logic [7:0] r;
    #1 cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      b = (i == 0) ? op : (i == 1) ? arg : 8'h00;
      for (int k = 7; k >= 0; k--) begin
        mosi = b[k];
        #40 sck = 1'b1;
        r[k] = miso;
        #40 sck = 1'b0;
      end
      rx_bytes[i] = r;
    end
    #40 cs_n = 1'b1;
    mosi = ~mosi; // released line must not look held
    #100;
  endtask : frame
endmodule : spi_host_model
